/* File: tsr_pkg.sv */
// Shared constants and types for the target state and tx length registers
package tsr_pkg;

  // Register offsets
  localparam logic [7:0] ADDR_TARGET_STATE = 8'h21;
  localparam logic [7:0] ADDR_TX_COUNT_UPPER = 8'h22;
  localparam logic [7:0] ADDR_TX_COUNT_LOWER = 8'h23;
  localparam logic [7:0] ADDR_RATE_STATUS = 8'h24;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h30;
  localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h31;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h32;

  // Field layout
  localparam int TX_COUNT_WIDTH = 13;
  localparam int TX_COUNT_MAX = 8191;
  localparam int TX_EXTRA_WIDTH = 3;
  localparam int LOWER_COUNT_LSB = 3;
  localparam int LOWER_COUNT_BITS = 5;
  localparam int RATE_STATUS_BITS = 6;
  localparam int TARGET_STATE_BITS = 4;

  // Reset values
  localparam logic [7:0] TX_COUNT_UPPER_RESET = 8'h00;
  localparam logic [7:0] TX_COUNT_LOWER_RESET = 8'h00;
  localparam logic [3:0] IRQ_ENABLE_RESET = 4'h0;

  // Interrupt status bit positions
  localparam int IRQ_BITS = 4;
  localparam int IRQ_PARITY = 0;
  localparam int IRQ_ACTIVE = 1;
  localparam int IRQ_ACTIVE_STAR = 2;
  localparam int IRQ_SPLIT_DONE = 3;

  // Passive target state codes; codes not listed are reserved
  typedef enum logic [3:0] {
    PTA_POWER_OFF = 4'h0,
    PTA_IDLE = 4'h1,
    PTA_READY_L1 = 4'h2,
    PTA_READY_L2 = 4'h3,
    PTA_ACTIVE = 4'h5,
    PTA_HALT = 4'h9,
    PTA_READY_L1_STAR = 4'hA,
    PTA_READY_L2_STAR = 4'hB,
    PTA_ACTIVE_STAR = 4'hD
  } tsr_pta_state_t;

  // Transmit length handed to the transmitter
  typedef struct packed {
    logic [12:0] fullByteCount;
    logic [2:0] extraBitCount;
  } tsr_tx_len_t;

  // Rate detection result and timer run flags, in register bit order
  typedef struct packed {
    logic [1:0] detectedBitRate;
    logic secondPowerOnTimerRunning;
    logic generalTimerRunning;
    logic noResponseTimerRunning;
    logic maskReceiveTimerRunning;
  } tsr_rate_timer_t;

endpackage

/* File: tsr_bit_serializer.sv */
// Shifts out the trailing partial byte of a frame, lowest bit first
`timescale 1ns/1ns
module tsr_bit_serializer
  import tsr_pkg::*;
#(
  parameter int DATA_WIDTH = 8,
  parameter int CNT_WIDTH = 3
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clkEn,
  input wire logic start,
  input wire logic [DATA_WIDTH-1:0] data,
  input wire logic [CNT_WIDTH-1:0] bitCount,
  output logic serialBit,
  output logic serialValid,
  output logic busy,
  output logic done
);

  // A partial byte must fit the counter and leave at least one bit short
  if (DATA_WIDTH < 2 || (1 << CNT_WIDTH) != DATA_WIDTH) begin : g_chk
    $error("tsr_bit_serializer: DATA_WIDTH must equal 2**CNT_WIDTH");
  end

  typedef enum logic {
    SER_IDLE = 1'b0,
    SER_SHIFT = 1'b1
  } tsr_ser_state_t;

  tsr_ser_state_t state_ff;
  logic [DATA_WIDTH-1:0] shift_ff;
  logic [CNT_WIDTH-1:0] left_ff;
  logic serialBit_ff;
  logic serialValid_ff;
  logic done_ff;

  // Sequencer; a zero count never starts, so full bytes pass untouched
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= SER_IDLE;
      shift_ff <= '0;
      left_ff <= '0;
    end else if (clkEn) begin
      unique case (state_ff)
        SER_IDLE: begin
          if (start && bitCount != '0) begin
            shift_ff <= data;
            left_ff <= bitCount;
            state_ff <= SER_SHIFT;
          end
        end
        SER_SHIFT: begin
          shift_ff <= shift_ff >> 1;
          left_ff <= left_ff - CNT_WIDTH'(1);
          if (left_ff == CNT_WIDTH'(1)) begin
            state_ff <= SER_IDLE;
          end
        end
      endcase
    end
  end

  // Registered outputs trail the state by one cycle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      serialBit_ff <= 1'b0;
      serialValid_ff <= 1'b0;
      done_ff <= 1'b0;
    end else if (clkEn) begin
      serialBit_ff <= (state_ff == SER_SHIFT) & shift_ff[0];
      serialValid_ff <= (state_ff == SER_SHIFT);
      done_ff <= (state_ff == SER_SHIFT) && (left_ff == CNT_WIDTH'(1));
    end
  end

  assign serialBit = serialBit_ff;
  assign serialValid = serialValid_ff;
  assign busy = state_ff;
  assign done = done_ff;

endmodule

/* File: target_state_tx_length_regs.sv */
// Target state view, transmit length and rate/timer status registers
// How it works
// - Report 4-bit passive target state code
// - Hold 13-bit full byte count, max 8191
// - Count split: upper byte, then bits 7:3
// - Bits 2:0 give extra bits; zero none
// - Partial byte is sent lowest bit first
// - No parity generated for split-byte frames
// - Parity error on REQA/WUPA with extra bits
// - Detected bit rate in status bits 5:4
// - Status bits 3:0 show running timers
`timescale 1ns/1ns
module target_state_tx_length_regs
  import tsr_pkg::*;
#(
  parameter int ADDR_WIDTH = 8
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clkEn,
  input wire logic [ADDR_WIDTH-1:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdData,
  input wire logic [3:0] targetState,
  input wire tsr_rate_timer_t rateTimer,
  input wire logic anticollisionControl,
  input wire logic cardIdle,
  input wire logic reqaWupaCmd,
  input wire logic splitStart,
  input wire logic [7:0] splitByte,
  output tsr_tx_len_t txLen,
  output logic txParityEnable,
  output logic parityErrorIrq,
  output logic serialBit,
  output logic serialValid,
  output logic serialBusy,
  output logic irq
);

  // The highest offset is eight bits wide
  if (ADDR_WIDTH < 8) begin : g_chk
    $error("target_state_tx_length_regs: ADDR_WIDTH must be at least 8");
  end

  // Address match, shared by the write and read decoders
  function automatic logic addrHit(
    input logic [ADDR_WIDTH-1:0] addr,
    input logic [7:0] offset
  );
    return addr == ADDR_WIDTH'(offset);
  endfunction

  logic [7:0] countUpper_ff;
  logic [LOWER_COUNT_BITS-1:0] countLower_ff;
  logic [TX_EXTRA_WIDTH-1:0] extraBits_ff;
  tsr_tx_len_t txLen_ff;
  logic txParityEnable_ff;
  logic parityErrorIrq_ff;
  logic [7:0] regRdData_ff;
  logic [3:0] targetState_ff;
  logic [3:0] prevState_ff;
  tsr_rate_timer_t rateTimer_ff;
  logic [IRQ_BITS-1:0] irqStatus_ff;
  logic [IRQ_BITS-1:0] irqEnable_ff;
  logic irq_ff;
  logic [IRQ_BITS-1:0] nxt_irqStatus;
  logic [IRQ_BITS-1:0] irqEvents;
  logic [IRQ_BITS-1:0] irqClear;
  logic parityEvent;
  logic splitDone;
  logic wrUpper;
  logic wrLower;
  logic wrClear;
  logic wrEnable;

  // Write decode
  assign wrUpper = regWr && addrHit(regAddr, ADDR_TX_COUNT_UPPER);
  assign wrLower = regWr && addrHit(regAddr, ADDR_TX_COUNT_LOWER);
  assign wrClear = regWr && addrHit(regAddr, ADDR_IRQ_CLEAR);
  assign wrEnable = regWr && addrHit(regAddr, ADDR_IRQ_ENABLE);

  // Upper eight count bits; the 13-bit field caps the count at 8191
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      countUpper_ff <= TX_COUNT_UPPER_RESET;
    end else if (clkEn && wrUpper) begin
      countUpper_ff <= regWrData;
    end
  end

  // Lower count bits sit above the extra-bit field
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      countLower_ff <= TX_COUNT_LOWER_RESET[7:LOWER_COUNT_LSB];
      extraBits_ff <= TX_COUNT_LOWER_RESET[TX_EXTRA_WIDTH-1:0];
    end else if (clkEn && wrLower) begin
      countLower_ff <= regWrData[7:LOWER_COUNT_LSB];
      extraBits_ff <= regWrData[TX_EXTRA_WIDTH-1:0];
    end
  end

  // Length view for the transmitter, one cycle behind the registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      txLen_ff <= '0;
    end else if (clkEn) begin
      txLen_ff.fullByteCount <= {countUpper_ff, countLower_ff};
      txLen_ff.extraBitCount <= extraBits_ff;
    end
  end

  // Parity is only generated when the frame ends on a whole byte
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      txParityEnable_ff <= 1'b1;
    end else if (clkEn) begin
      txParityEnable_ff <= (extraBits_ff == '0);
    end
  end

  // Short frames rely on the host choosing the no-CRC transmit command
  tsr_bit_serializer #(
    .DATA_WIDTH(8),
    .CNT_WIDTH(TX_EXTRA_WIDTH)
  ) u_split_byte (
    .clk(clk),
    .reset_n(reset_n),
    .clkEn(clkEn),
    .start(splitStart),
    .data(splitByte),
    .bitCount(extraBits_ff),
    .serialBit(serialBit),
    .serialValid(serialValid),
    .busy(serialBusy),
    .done(splitDone)
  );

  // REQA/WUPA with a split byte pending is flagged as a parity fault
  assign parityEvent = reqaWupaCmd && anticollisionControl && cardIdle
    && (extraBits_ff != '0);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      parityErrorIrq_ff <= 1'b0;
    end else if (clkEn) begin
      parityErrorIrq_ff <= parityEvent;
    end
  end

  // State and status snapshots; inputs come from logic on this clock
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      targetState_ff <= PTA_POWER_OFF;
      prevState_ff <= PTA_POWER_OFF;
      rateTimer_ff <= '0;
    end else if (clkEn) begin
      targetState_ff <= targetState;
      prevState_ff <= targetState_ff;
      rateTimer_ff <= rateTimer;
    end
  end

  // Entry into ACTIVE or ACTIVE* hands command handling to the host
  always_comb begin
    irqEvents = '0;
    irqEvents[IRQ_PARITY] = parityEvent;
    irqEvents[IRQ_ACTIVE] = (targetState_ff == PTA_ACTIVE)
      && (prevState_ff != PTA_ACTIVE);
    irqEvents[IRQ_ACTIVE_STAR] = (targetState_ff == PTA_ACTIVE_STAR)
      && (prevState_ff != PTA_ACTIVE_STAR);
    irqEvents[IRQ_SPLIT_DONE] = splitDone;
  end

  // Sticky status; an event in the clearing cycle survives the clear
  assign irqClear = wrClear ? regWrData[IRQ_BITS-1:0] : '0;
  assign nxt_irqStatus = (irqStatus_ff & ~irqClear) | irqEvents;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irqStatus_ff <= '0;
    end else if (clkEn) begin
      irqStatus_ff <= nxt_irqStatus;
    end
  end

  // Interrupt enable mask
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irqEnable_ff <= IRQ_ENABLE_RESET;
    end else if (clkEn && wrEnable) begin
      irqEnable_ff <= regWrData[IRQ_BITS-1:0];
    end
  end

  // Level interrupt, one cycle behind the status it reflects
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_ff <= 1'b0;
    end else if (clkEn) begin
      irq_ff <= |(irqStatus_ff & irqEnable_ff);
    end
  end

  // Read port: data valid only in the cycle after the strobe.
  // Reads change nothing, so polling never disturbs the status views.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      regRdData_ff <= 8'h00;
    end else if (clkEn) begin
      regRdData_ff <= 8'h00;
      if (regRd) begin
        if (addrHit(regAddr, ADDR_TARGET_STATE)) begin
          regRdData_ff <= {4'h0, targetState_ff};
        end else if (addrHit(regAddr, ADDR_TX_COUNT_UPPER)) begin
          regRdData_ff <= countUpper_ff;
        end else if (addrHit(regAddr, ADDR_TX_COUNT_LOWER)) begin
          regRdData_ff <= {countLower_ff, extraBits_ff};
        end else if (addrHit(regAddr, ADDR_RATE_STATUS)) begin
          regRdData_ff <= {2'h0, rateTimer_ff};
        end else if (addrHit(regAddr, ADDR_IRQ_STATUS)) begin
          regRdData_ff <= {4'h0, irqStatus_ff};
        end else if (addrHit(regAddr, ADDR_IRQ_ENABLE)) begin
          regRdData_ff <= {4'h0, irqEnable_ff};
        end
      end
    end
  end

  assign regRdData = regRdData_ff;
  assign txLen = txLen_ff;
  assign txParityEnable = txParityEnable_ff;
  assign parityErrorIrq = parityErrorIrq_ff;
  assign irq = irq_ff;

endmodule

/* File: tsr_asserts.sv */
// Port-level checks for the target state and tx length registers
`timescale 1ns/1ns
module tsr_asserts
  import tsr_pkg::*;
#(
  parameter int ADDR_WIDTH = 8
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clkEn,
  input wire logic [ADDR_WIDTH-1:0] regAddr,
  input wire logic regRd,
  input wire logic [7:0] regRdData,
  input wire logic [3:0] targetState,
  input wire tsr_rate_timer_t rateTimer,
  input wire logic anticollisionControl,
  input wire logic cardIdle,
  input wire logic reqaWupaCmd,
  input wire logic splitStart,
  input wire logic [7:0] splitByte,
  input wire tsr_tx_len_t txLen,
  input wire logic txParityEnable,
  input wire logic parityErrorIrq,
  input wire logic serialBit,
  input wire logic serialValid,
  input wire logic serialBusy
);
  logic rdEn;
  logic hit;

  // One domain, so clock and reset are given once
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  // Qualifying conditions shared by several checks
  assign rdEn = regRd && clkEn;
  assign hit = reqaWupaCmd && anticollisionControl && cardIdle;

  // A frozen cycle holds the read data, so only a live idle cycle counts
  a_rd_idle_zero: assert property (clkEn && !regRd |=> regRdData == 8'h00)
    else $error("read data not zero outside a read");
  a_state_view: assert property (rdEn && regAddr == ADDR_TARGET_STATE
    && $stable(targetState) |=> regRdData == {4'h0, $past(targetState)})
    else $error("target state read wrong");
  a_rate_view: assert property (rdEn && regAddr == ADDR_RATE_STATUS
    && $stable(rateTimer) |=> regRdData == {2'b00, $past(rateTimer)})
    else $error("rate and timer status read wrong");
  a_count_upper: assert property (rdEn && regAddr == ADDR_TX_COUNT_UPPER
    |=> regRdData == txLen.fullByteCount[12:5])
    else $error("upper count read differs from txLen");
  a_count_lower: assert property (rdEn && regAddr == ADDR_TX_COUNT_LOWER
    |=> regRdData == {txLen.fullByteCount[4:0], txLen.extraBitCount})
    else $error("lower count read differs from txLen");
  a_parity_off: assert property (txParityEnable ==
    (txLen.extraBitCount == 3'h0))
    else $error("parity enable disagrees with extra bits");
  a_parity_raise: assert property (hit && txLen.extraBitCount != 3'h0
    |=> parityErrorIrq ##1 !parityErrorIrq)
    else $error("parity error pulse missing");
  a_parity_cause: assert property (parityErrorIrq |-> $past(hit))
    else $error("parity error without command");
  // Three bits, lowest first, then the line goes quiet
  a_split_lsb: assert property (splitStart && !serialBusy
    && txLen.extraBitCount == 3'h3 |-> ##1 serialBusy
    ##1 serialValid && serialBit == $past(splitByte[0], 2)
    ##1 serialValid && serialBit == $past(splitByte[1], 3)
    ##1 serialValid && serialBit == $past(splitByte[2], 4)
    ##1 !serialValid)
    else $error("partial byte bits wrong");
endmodule

bind target_state_tx_length_regs tsr_asserts #(.ADDR_WIDTH(ADDR_WIDTH))
  u_chk (.clk, .reset_n, .clkEn, .regAddr, .regRd, .regRdData,
  .targetState, .rateTimer, .anticollisionControl, .cardIdle, .reqaWupaCmd,
  .splitStart, .splitByte, .txLen, .txParityEnable, .parityErrorIrq,
  .serialBit, .serialValid, .serialBusy);

/* File: tsr_host_model.sv */
// Host model: drives the register port one strobe at a time
`timescale 1ns/1ns
module tsr_host_model (
  input wire logic clk,
  output logic [7:0] regAddr,
  output logic [7:0] regWrData,
  output logic regWr,
  output logic regRd,
  input wire logic [7:0] regRdData
);
  // Idle bus at time zero; no RF commands issued from here
  initial begin
    regAddr = 8'h00;
    regWrData = 8'h00;
    regWr = 1'b0;
    regRd = 1'b0;
  end

  // One-cycle write; an 8-bit field cannot push the count past 8191
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk);
    regWr <= 1'b0;
    regAddr <= ~a; // Released lines do not keep the old value
    regWrData <= ~d;
  endtask

  // Data stand only in the cycle after the strobe, so take it mid-cycle
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    regAddr <= ~a;
    @(negedge clk);
    d = regRdData;
  endtask
endmodule

/* File: test_target_state_tx_length_regs.sv */
// Directed register-level test of the target state and tx length block
`timescale 1ns/1ns
module test_target_state_tx_length_regs
  import tsr_pkg::*;
;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic clkEn = 1'b1;
  logic [7:0] regAddr, regWrData, regRdData, bits;
  logic regWr, regRd, serialBit, serialValid, serialBusy, irq;
  logic [3:0] targetState = 4'h0;
  tsr_rate_timer_t rateTimer = 6'h00;
  logic anticollisionControl = 1'b0;
  logic cardIdle = 1'b0;
  logic reqaWupaCmd = 1'b0;
  logic splitStart = 1'b0;
  logic [7:0] splitByte = 8'h00;
  tsr_tx_len_t txLen;
  logic txParityEnable, parityErrorIrq;
  logic [15:0] nBits;
  logic [3:0] codes [10] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h5, 4'h9, 4'hA,
    4'hB, 4'hD, 4'hC};
  logic [5:0] rates [2] = '{6'h2A, 6'h15};
  int n_errors = 0;
  int comparisons = 0;
  int cycles = 0;

  tsr_host_model host (.clk, .regAddr, .regWrData, .regWr, .regRd,
    .regRdData);
  target_state_tx_length_regs DUT (.clk, .reset_n, .clkEn, .regAddr,
    .regWrData, .regWr, .regRd, .regRdData, .targetState, .rateTimer,
    .anticollisionControl, .cardIdle, .reqaWupaCmd, .splitStart, .splitByte,
    .txLen, .txParityEnable, .parityErrorIrq, .serialBit, .serialValid,
    .serialBusy, .irq);

  // 50 MHz clock
  initial forever #10 clk = ~clk;

  task automatic test_done();
    if (n_errors == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic rdChk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    host.rd(a, d);
    chk({8'h00, d}, {8'h00, e});
  endtask

  // Pulse the direct command for one cycle, look at the pulse after it
  task automatic cmdPulse(input logic e);
    @(posedge clk);
    reqaWupaCmd <= 1'b1;
    @(posedge clk);
    reqaWupaCmd <= 1'b0;
    @(negedge clk);
    chk({15'h0000, parityErrorIrq}, {15'h0000, e});
  endtask

  // Hang guard, far beyond the roughly 120 cycles needed
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_errors++;
      test_done();
    end
  end

  initial begin
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk);
    rdChk(ADDR_TX_COUNT_UPPER, TX_COUNT_UPPER_RESET);
    rdChk(ADDR_TX_COUNT_LOWER, TX_COUNT_LOWER_RESET);
    host.wr(ADDR_TX_COUNT_UPPER, 8'hFF);
    host.wr(ADDR_TX_COUNT_LOWER, 8'hFB);
    rdChk(ADDR_TX_COUNT_UPPER, 8'hFF);
    rdChk(ADDR_TX_COUNT_LOWER, 8'hFB);
    chk(txLen, 16'hFFFB);
    chk({15'h0000, txParityEnable}, 16'h0000);
    host.wr(ADDR_RATE_STATUS, 8'hFF);
    rdChk(8'h40, 8'h00);
    // Every listed state code and one reserved code, read back raw
    foreach (codes[i]) begin
      @(posedge clk);
      targetState <= codes[i];
      repeat (2) @(posedge clk);
      rdChk(ADDR_TARGET_STATE, {4'h0, codes[i]});
    end
    foreach (rates[i]) begin
      @(posedge clk);
      rateTimer <= rates[i];
      repeat (2) @(posedge clk);
      rdChk(ADDR_RATE_STATUS, {2'b00, rates[i]});
    end
    // Clock enable low freezes state, so this write must not land
    @(posedge clk);
    clkEn <= 1'b0;
    host.wr(ADDR_TX_COUNT_UPPER, 8'h12);
    @(posedge clk);
    clkEn <= 1'b1;
    rdChk(ADDR_TX_COUNT_UPPER, 8'hFF);
    // Entries into ACTIVE and ACTIVE* were latched by the state walk
    rdChk(ADDR_IRQ_STATUS, 8'h06);
    // Parity error with extra bits set, seen through the interrupt
    host.wr(ADDR_IRQ_CLEAR, 8'h0F);
    host.wr(ADDR_IRQ_ENABLE, 8'h01);
    rdChk(ADDR_IRQ_ENABLE, 8'h01);
    rdChk(ADDR_IRQ_STATUS, 8'h00);
    @(posedge clk);
    anticollisionControl <= 1'b1;
    cardIdle <= 1'b1;
    cmdPulse(1'b1);
    @(negedge clk);
    chk({15'h0000, irq}, 16'h0001);
    rdChk(ADDR_IRQ_STATUS, 8'h01);
    host.wr(ADDR_IRQ_CLEAR, 8'h01);
    repeat (2) @(negedge clk);
    chk({15'h0000, irq}, 16'h0000);
    // Three trailing bits of 0xF6 must leave as 0,1,1
    @(posedge clk);
    splitByte <= 8'hF6;
    splitStart <= 1'b1;
    @(posedge clk);
    splitStart <= 1'b0;
    nBits = 16'h0000;
    bits = 8'h00;
    repeat (6) begin
      @(negedge clk);
      if (serialValid === 1'b1) begin
        bits[nBits[2:0]] = serialBit;
        nBits++;
      end
    end
    chk(nBits, 16'h0003);
    chk({8'h00, bits}, 16'h0006);
    rdChk(ADDR_IRQ_STATUS, 8'h08);
    // Zero extra bits: full bytes only, parity back on, no error
    host.wr(ADDR_TX_COUNT_LOWER, 8'hF8);
    repeat (2) @(negedge clk);
    chk({15'h0000, txParityEnable}, 16'h0001);
    cmdPulse(1'b0);
    test_done();
  end
endmodule
